/* File: hw/dim_pkg.sv */
// dim_pkg: constants for the DRAM init and mode-setup device block
// assumes: single 10 MHz ref_clk domain, command pins already sampled
package dim_pkg;
  // ==========================================================
  // command decode (active low pins)
  localparam logic [3:0] CMD_MODE_WRITE = 4'h0; // cs,ras,cas,we all low
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [2:0] BANK_MODE = 3'h0;
  localparam logic [2:0] BANK_EXT1 = 3'h1;
  localparam logic [2:0] BANK_EXT2 = 3'h2;
  localparam logic [2:0] BANK_EXT3 = 3'h3;
  localparam int PRE_ALL_BIT = 10;
  // ==========================================================
  // mode word fields
  localparam int WORD_W = 14;
  localparam int BL_LSB = 0;
  localparam int BL_W = 3;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int CL_W = 3;
  localparam int TM_BIT = 7;
  localparam int DLLRST_BIT = 8;
  localparam int WR_LSB = 9;
  localparam int WR_W = 3;
  localparam int RSV_BIT = 13;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] CL_MIN_CODE = 3'h3;
  localparam logic [2:0] WR_MIN_CODE = 3'h1;
  // ext word 1: dll enable (low = on), driver calibration field
  localparam int DLL_OFF_BIT = 0;
  localparam int CAL_LSB = 7;
  localparam int CAL_W = 3;
  localparam logic [2:0] CAL_DEFAULT = 3'h7;
  localparam logic [2:0] CAL_EXIT = 3'h0;
  // ==========================================================
  // timing
  localparam int CLK_NS = 100;
  localparam int LOCK_CYCLES = 200;
  localparam int LOCK_W = 8;
  localparam int MRD_CYCLES = 2;
  localparam int REF_MIN = 2;
endpackage

/* File: hw/dim_cfg_store.sv */
// dim_cfg_store: four configuration words held in a tiny register memory
// assumes: one write port, registered read of all words for decode
`timescale 1ns/1ps
module dim_cfg_store #(
  parameter int WIDTH = dim_pkg::WORD_W,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // write port
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrSel,
  input wire logic [WIDTH-1:0] wrData,
  // registered contents
  output logic [DEPTH-1:0][WIDTH-1:0] words
);
  // ==========================================================
  // storage
  // contents are cleared to zero by nrst, so they are never left undefined after reset
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
  } dim_store_t;
  dim_store_t st;
  dim_store_t next_st;
  always_comb begin
    next_st = st;
    for (int i = 0; i < DEPTH; i++) begin
      if (wrEn && wrSel == i[$clog2(DEPTH)-1:0]) begin
        next_st.mem[i] = wrData;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign words = st.mem;
endmodule

/* File: hw/dim_init_dev.sv */
// dim_init_dev: device side of power-up init and mode register programming
// assumes: command pins already synchronous to ref_clk (controller logic on same clock)
// Operation
// R1 - controller holds clock gate and termination enable low during supply ramp.
// R2 - controller starts the clock and keeps it stable first.
// R3 - after 200 us stable, controller drives nop and raises clock gate.
// R4 - nop only for 400 ns after clock gate rise, then precharge all.
// R5 - after precharge, write extended word 2 then extended word 3.
// R6 - then enable delay loop by ext write, then mode write with loop reset.
// R7 - then precharge all and at least two auto refreshes.
// R8 - then mode write with A8 low programs operating parameters.
// R9 - 200 clocks after loop reset, calibration default then calibration exit.
// R10 - every field must be valid whenever a word is rewritten; the device checks only mode word fields, not the extended words.
// R11 - mode writes and loop resets leave array data untouched.
// R12 - mode word undefined after power-up; must be written before use.
// R13 - mode write: all control and bank pins low; value from A0-A13.
// R14 - before mode write, banks precharged and clock gate high.
// R15 - wait the mode write gap after each mode write.
// R16 - A0-A2 select burst length, only 4 or 8 supported.
// R17 - A3 burst order, A4-A6 read latency, whole clocks only.
// R18 - A7 test select must be low; A8 requests loop reset.
// R19 - A9-A11 hold write recovery cycles for auto-precharge.
// R20 - A13 reserved, written zero.
// R21 - write recovery field is time over clock period, rounded up.
// R22 - 200 clocks after loop enable and reset before any read.
// R23 - controller drives nop between steps.
// R24 - init done only after calibration exit and its gap.
`timescale 1ns/1ps
module dim_init_dev #(
  parameter int LOCK_CYC = dim_pkg::LOCK_CYCLES,
  parameter int MRD_CYC = dim_pkg::MRD_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // command pins
  input wire logic clkGate,
  input wire logic termination_enable,
  input wire logic chipSel_n,
  input wire logic rowStrobe_n,
  input wire logic colStrobe_n,
  input wire logic writeEn_n,
  input wire logic [2:0] bankSel,
  input wire logic [13:0] addr,
  // decoded configuration and status flags
  output logic [2:0] burstLen,
  output logic burst_order_bit,
  output logic [2:0] readLatency,
  output logic [2:0] writeRecovery,
  output logic dllOn,
  output logic dllLocked,
  output logic readAllowed,
  output logic initDone,
  output logic seqError,
  output logic cfgError
);
  typedef enum logic [3:0] {
    ST_POWER, ST_PRE1, ST_EXT2, ST_EXT3, ST_DLL_EN, ST_DLL_RST,
    ST_PRE2, ST_REFRESH, ST_MODE, ST_CAL_DEF, ST_CAL_EXIT, ST_READY
  } dim_state_t;
  typedef struct packed {
    dim_state_t state;
    logic [1:0] refCnt;
    logic [dim_pkg::LOCK_W-1:0] lockCnt;
    logic locking;
    logic [1:0] gapCnt;
    logic modeValid;
    logic dllOn;
    logic done;
    logic seqErr;
    logic cfgErr;
  } dim_ctl_t;
  dim_ctl_t st;
  dim_ctl_t next_st;
  // ==========================================================
  // command decode
  logic [3:0] cmd;
  logic modeWr;
  logic preAll;
  logic refresh;
  logic [dim_pkg::WORD_W-1:0] modeWord;
  logic [dim_pkg::WORD_W-1:0] ext1Word;
  logic [3:0][dim_pkg::WORD_W-1:0] words;
  logic [2:0] calField;
  logic otherCmd;
  assign cmd = {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n};
  assign modeWr = clkGate && cmd == dim_pkg::CMD_MODE_WRITE; // [R13] [R14]
  assign preAll = clkGate && cmd == dim_pkg::CMD_PRECHARGE && addr[dim_pkg::PRE_ALL_BIT];
  assign refresh = clkGate && cmd == dim_pkg::CMD_REFRESH;
  assign otherCmd = clkGate && !chipSel_n && !(rowStrobe_n && colStrobe_n && writeEn_n);
  assign calField = addr[dim_pkg::CAL_LSB +: dim_pkg::CAL_W];
  // ==========================================================
  // word store; writes never touch array data, only config [R11]
  dim_cfg_store #(
    .WIDTH(dim_pkg::WORD_W),
    .DEPTH(4)
  ) u_store (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .wrEn(modeWr && !bankSel[2]), // upper bank pin set selects no word [R13]
    .wrSel(bankSel[1:0]),
    .wrData(addr), // [R13]
    .words(words)
  );
  assign modeWord = words[0];
  assign ext1Word = words[1];
  // ==========================================================
  // sequence tracker
  function automatic logic isBank(input logic [2:0] b, input logic [2:0] want);
    isBank = (b == want);
  endfunction
  always_comb begin
    next_st = st;
    if (st.gapCnt != 2'h0) begin
      next_st.gapCnt = st.gapCnt - 2'h1;
    end
    if (st.locking && st.lockCnt != '0) begin
      next_st.lockCnt = st.lockCnt - 1'b1; // [R22]
    end
    // command during the mode write gap is a sequencing fault [R15]
    if (st.gapCnt != 2'h0 && otherCmd) begin
      next_st.seqErr = 1'b1;
    end
    if (modeWr) begin
      next_st.gapCnt = 2'(MRD_CYC - 1); // [R15]
      if (isBank(bankSel, dim_pkg::BANK_EXT1)) begin
        next_st.dllOn = !addr[dim_pkg::DLL_OFF_BIT];
      end
      // calibration before lock is flagged in any state, but still taken
      if (isBank(bankSel, dim_pkg::BANK_EXT1) && calField == dim_pkg::CAL_DEFAULT &&
          !(st.locking && st.lockCnt == '0)) begin
        next_st.seqErr = 1'b1; // [R9]
      end
      if (isBank(bankSel, dim_pkg::BANK_MODE)) begin
        next_st.modeValid = 1'b1; // [R12]
        if (addr[dim_pkg::DLLRST_BIT]) begin
          next_st.locking = 1'b1; // [R18]
          next_st.lockCnt = dim_pkg::LOCK_W'(LOCK_CYC - 1);
        end
        // unsupported codes flagged, not silently accepted [R16] [R17] [R19] [R20]
        if ((addr[dim_pkg::BL_LSB +: dim_pkg::BL_W] != dim_pkg::BL_CODE_4 &&
             addr[dim_pkg::BL_LSB +: dim_pkg::BL_W] != dim_pkg::BL_CODE_8) ||
            addr[dim_pkg::CL_LSB +: dim_pkg::CL_W] < dim_pkg::CL_MIN_CODE ||
            addr[dim_pkg::WR_LSB +: dim_pkg::WR_W] < dim_pkg::WR_MIN_CODE ||
            addr[dim_pkg::TM_BIT] || addr[dim_pkg::RSV_BIT]) begin
          next_st.cfgErr = 1'b1;
        end
      end
    end
    unique case (st.state)
      ST_POWER: begin
        if (preAll) next_st.state = ST_PRE1; // [R4]
      end
      ST_PRE1: begin
        if (modeWr && isBank(bankSel, dim_pkg::BANK_EXT2)) next_st.state = ST_EXT2; // [R5]
      end
      ST_EXT2: begin
        if (modeWr && isBank(bankSel, dim_pkg::BANK_EXT3)) next_st.state = ST_EXT3; // [R5]
      end
      ST_EXT3: begin
        if (modeWr && isBank(bankSel, dim_pkg::BANK_EXT1) && !addr[dim_pkg::DLL_OFF_BIT]) begin
          next_st.state = ST_DLL_EN; // [R6]
        end
      end
      ST_DLL_EN: begin
        if (modeWr && isBank(bankSel, dim_pkg::BANK_MODE) && addr[dim_pkg::DLLRST_BIT]) begin
          next_st.state = ST_DLL_RST; // [R6]
        end
      end
      ST_DLL_RST: begin
        if (preAll) next_st.state = ST_PRE2; // [R7]
      end
      ST_PRE2: begin
        if (refresh) begin
          next_st.refCnt = 2'h1;
          next_st.state = ST_REFRESH;
        end
      end
      ST_REFRESH: begin
        if (refresh && st.refCnt != 2'h3) next_st.refCnt = st.refCnt + 2'h1; // [R7]
        if (modeWr && isBank(bankSel, dim_pkg::BANK_MODE) && !addr[dim_pkg::DLLRST_BIT] &&
            st.refCnt >= 2'(dim_pkg::REF_MIN)) begin
          next_st.state = ST_MODE; // [R8]
        end
      end
      ST_MODE: begin
        if (modeWr && isBank(bankSel, dim_pkg::BANK_EXT1) &&
            calField == dim_pkg::CAL_DEFAULT) begin
          next_st.state = ST_CAL_DEF; // [R9]
        end
      end
      ST_CAL_DEF: begin
        if (modeWr && isBank(bankSel, dim_pkg::BANK_EXT1) && calField == dim_pkg::CAL_EXIT) begin
          next_st.state = ST_CAL_EXIT; // [R9]
        end
      end
      ST_CAL_EXIT: begin
        if (st.gapCnt == 2'h0) begin
          next_st.state = ST_READY;
          next_st.done = 1'b1; // [R24]
        end
      end
      ST_READY: begin
        // re-programming later is legal when banks are idle
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{state: ST_POWER, default: '0};
    end else begin
      st <= next_st;
    end
  end
  // ==========================================================
  // decoded outputs, registered via the store
  assign burstLen = modeWord[dim_pkg::BL_LSB +: dim_pkg::BL_W]; // [R16]
  assign burst_order_bit = modeWord[dim_pkg::BT_BIT]; // [R17]
  assign readLatency = modeWord[dim_pkg::CL_LSB +: dim_pkg::CL_W]; // [R17]
  assign writeRecovery = modeWord[dim_pkg::WR_LSB +: dim_pkg::WR_W]; // [R19]
  assign dllOn = st.dllOn && !ext1Word[dim_pkg::DLL_OFF_BIT];
  assign dllLocked = st.locking && st.lockCnt == '0;
  assign readAllowed = dllLocked && st.done && st.modeValid; // [R22] [R12]
  assign initDone = st.done;
  assign seqError = st.seqErr;
  assign cfgError = st.cfgErr;
endmodule

/* File: sim/dim_init_dev_props.sv */
// checker: port-level behaviour of dim_init_dev
// assumes: bound onto every dim_init_dev instance
`timescale 1ns/1ps
module dim_init_dev_props #(
  parameter int LOCK_CYC = 200,
  parameter int MRD_CYC = 2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // command pins
  input wire logic clkGate,
  input wire logic chipSel_n,
  input wire logic rowStrobe_n,
  input wire logic colStrobe_n,
  input wire logic writeEn_n,
  input wire logic [2:0] bankSel,
  input wire logic [13:0] addr,
  // watched outputs
  input wire logic [2:0] burstLen,
  input wire logic burst_order_bit,
  input wire logic [2:0] readLatency,
  input wire logic [2:0] writeRecovery,
  input wire logic dllOn,
  input wire logic dllLocked,
  input wire logic readAllowed,
  input wire logic initDone,
  input wire logic seqError,
  input wire logic cfgError
);
  localparam int LOCK_M1 = LOCK_CYC - 1;
  // done registers on the edge that ends the gap, so it is seen one edge later
  localparam int DONE_LAG = MRD_CYC + 1;
  logic wr;
  logic mrCmd;
  logic e1Cmd;
  logic calExit;
  logic badWord;
  logic [9:0] fld;
  assign wr = clkGate && {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n} == 4'h0;
  assign mrCmd = wr && bankSel == 3'h0;
  assign e1Cmd = wr && bankSel == 3'h1;
  assign calExit = e1Cmd && addr[9:7] == 3'h0;
  assign badWord = addr[7] || addr[13] || addr[2:1] != 2'h1 || addr[6:4] < 3'h3 ||
                   addr[11:9] == 3'h0;
  assign fld = {writeRecovery, readLatency, burst_order_bit, burstLen};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // properties
  sequence s_lock;
    ##LOCK_M1 !dllLocked ##1 dllLocked;
  endsequence
  property p_fields; mrCmd |=> fld == $past({addr[11:9], addr[6:0]}); endproperty
  property p_hold; !mrCmd |=> $stable(fld); endproperty
  property p_lock; mrCmd && addr[8] && !dllLocked |-> s_lock; endproperty
  property p_dll; e1Cmd |=> dllOn == !$past(addr[0]); endproperty
  property p_cfg; mrCmd && badWord |=> cfgError; endproperty
  property p_sticky; !$fell(cfgError) && !$fell(seqError) && !$fell(initDone); endproperty
  property p_early; e1Cmd && addr[9:7] == 3'h7 && !dllLocked |=> seqError; endproperty
  property p_ready; readAllowed == (dllLocked && initDone); endproperty
  property p_done; $rose(initDone) |-> $past(calExit, DONE_LAG); endproperty
  a_fields: assert property (p_fields) else $error("mode fields wrong");
  a_hold: assert property (p_hold) else $error("fields moved");
  a_lock: assert property (p_lock) else $error("lock timing wrong");
  a_dll: assert property (p_dll) else $error("dll enable wrong");
  a_cfg: assert property (p_cfg) else $error("bad word unflagged");
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  a_early: assert property (p_early) else $error("early cal unflagged");
  a_ready: assert property (p_ready) else $error("ready too soon");
  a_done: assert property (p_done) else $error("done timing wrong");
endmodule

bind dim_init_dev dim_init_dev_props #(.LOCK_CYC(LOCK_CYC), .MRD_CYC(MRD_CYC)) i_props (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .clkGate(clkGate),
  .chipSel_n(chipSel_n),
  .rowStrobe_n(rowStrobe_n),
  .colStrobe_n(colStrobe_n),
  .writeEn_n(writeEn_n),
  .bankSel(bankSel),
  .addr(addr),
  .burstLen(burstLen),
  .burst_order_bit(burst_order_bit),
  .readLatency(readLatency),
  .writeRecovery(writeRecovery),
  .dllOn(dllOn),
  .dllLocked(dllLocked),
  .readAllowed(readAllowed),
  .initDone(initDone),
  .seqError(seqError),
  .cfgError(cfgError)
);

/* File: sim/dim_ctl_model.sv */
// controller model: drives the command and address pins
// assumes: the bench steps it, one command per task call
`timescale 1ns/1ps
module dim_ctl_model (
  // clock
  input wire logic ref_clk,
  // command pins
  output logic clkGate,
  output logic termination_enable,
  output logic chipSel_n,
  output logic rowStrobe_n,
  output logic colStrobe_n,
  output logic writeEn_n,
  output logic [2:0] bankSel,
  output logic [13:0] addr
);
  // gate and termination low, deselected during ramp
  initial begin
    clkGate = 1'b0;
    termination_enable = 1'b0;
    {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n} = 4'hf;
    bankSel = 3'h0;
    addr = 14'h0000;
  end
  // one edge of command, then nop; bus scrambled so stale values never match
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    @(posedge ref_clk);
    #1;
    {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n} = c;
    bankSel = b;
    addr = a;
    @(posedge ref_clk);
    #1;
    {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n} = 4'h7;
    bankSel = ~b;
    addr = ~a;
  endtask
  // stable wait, gate up under nop, then 400 ns of nop
  task automatic power_up(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
    {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n} = 4'h7;
    clkGate = 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

/* File: sim/ddr2_init_and_mode_setup_test.sv */
// bench: dim_init_dev driven by the controller model
// assumes: 10 MHz clock, lock count cut to 20 cycles
`timescale 1ns/1ps
module ddr2_init_and_mode_setup_test;
  localparam int LOCK = 20;
  // write recovery time of the modelled part, rounded up to whole cycles
  localparam int WR_NS = 250;
  localparam logic [2:0] WR_CODE = 3'((WR_NS + dim_pkg::CLK_NS - 1) / dim_pkg::CLK_NS);
  logic ref_clk, nrst, clkGate, termination_enable;
  logic chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n;
  logic [2:0] bankSel, burstLen, readLatency, writeRecovery;
  logic [13:0] addr;
  logic burst_order_bit, dllOn, dllLocked, readAllowed, initDone, seqError, cfgError;
  int bad_count;
  int checks;
  wire [13:0] fld = {4'h0, writeRecovery, readLatency, burst_order_bit, burstLen};
  wire [13:0] flg = {8'h00, readAllowed, dllOn, dllLocked, initDone, seqError, cfgError};
  dim_init_dev #(.LOCK_CYC(LOCK)) i_dut (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clkGate(clkGate),
    .termination_enable(termination_enable),
    .chipSel_n(chipSel_n),
    .rowStrobe_n(rowStrobe_n),
    .colStrobe_n(colStrobe_n),
    .writeEn_n(writeEn_n),
    .bankSel(bankSel),
    .addr(addr),
    .burstLen(burstLen),
    .burst_order_bit(burst_order_bit),
    .readLatency(readLatency),
    .writeRecovery(writeRecovery),
    .dllOn(dllOn),
    .dllLocked(dllLocked),
    .readAllowed(readAllowed),
    .initDone(initDone),
    .seqError(seqError),
    .cfgError(cfgError)
  );
  dim_ctl_model i_ctl (
    .ref_clk(ref_clk),
    .clkGate(clkGate),
    .termination_enable(termination_enable),
    .chipSel_n(chipSel_n),
    .rowStrobe_n(rowStrobe_n),
    .colStrobe_n(colStrobe_n),
    .writeEn_n(writeEn_n),
    .bankSel(bankSel),
    .addr(addr)
  );
  // clock runs from time zero
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    nrst = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
  endtask
  task automatic mr(input logic [2:0] b, input logic [13:0] a);
    i_ctl.issue(4'h0, b, a); // whole word driven on every write
  endtask
  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_gated();
    mr(3'h0, 14'h0a33);
    settle();
    check(fld, 14'h0000);
    check(flg, 14'h0000);
    $display("gated test done");
  endtask
  task automatic t_init();
    i_ctl.power_up(2000);
    i_ctl.issue(4'h2, 3'h0, 14'h0400);
    mr(3'h2, 14'h0000);
    mr(3'h3, 14'h0000);
    mr(3'h1, 14'h0000);
    mr(3'h0, 14'h0b5b);
    settle();
    check(fld, {4'h0, 3'h5, 3'h5, 1'b1, 3'h3});
    check(flg, 14'h0010);
    i_ctl.issue(4'h2, 3'h0, 14'h0400);
    repeat (2) i_ctl.issue(4'h1, 3'h0, 14'h0000);
    mr(3'h0, {2'h0, WR_CODE, 9'h032}); // a13 kept zero
    settle();
    check(fld, {4'h0, WR_CODE, 3'h3, 1'b0, 3'h2});
    repeat (LOCK) settle();
    check(flg, 14'h0018);
    mr(3'h1, 14'h0380);
    mr(3'h1, 14'h0000);
    check(flg, 14'h0018);
    repeat (2) settle();
    check(flg, 14'h003c);
    $display("init test done");
  endtask
  task automatic t_early();
    do_reset();
    i_ctl.power_up(1);
    mr(3'h1, 14'h0380);
    settle();
    check(flg, 14'h0012);
    $display("early test done");
  endtask
  task automatic t_cfg();
    do_reset();
    mr(3'h0, 14'h00b3);
    settle();
    check(flg, 14'h0001);
    check(fld, {4'h0, 3'h0, 3'h3, 1'b0, 3'h3});
    $display("cfg test done");
  endtask
  initial begin
    bad_count = 0;
    checks = 0;
    do_reset();
    t_gated();
    t_init();
    t_early();
    t_cfg();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    conclude();
  end
endmodule
